// File: uam_pkg.sv
// package of constants for the uart auxiliary modes block
// assumes a 100 MHz core clock and a 16x oversampling tick from outside
package uam_pkg;
  // control bit positions
  localparam int SFR_ADDR_MARK_BIT = 7;
  localparam int SFR_IR_ENH_BIT = 3;
  localparam int EFR_ENH_EN_BIT = 4;
  localparam int MCR_IR_EN_BIT = 6;
  localparam int MCR_LOOP_BIT = 4;
  localparam int IER_SLEEP_BIT = 4;
  localparam int FCR_WAKE_INT_BIT = 3;
  localparam int LCR_PARITY_LSB = 3;
  localparam logic [2:0] LCR_PARITY_FORCE0 = 3'h7;
  // infrared pulse widths in sixteenths of a bit
  localparam logic [3:0] IR_SIXTEENTHS_BASIC = 4'h3;
  localparam logic [3:0] IR_SIXTEENTHS_ENH = 4'h4;
  // reset values
  localparam logic [7:0] RST_CTRL_REG = 8'h00;
  localparam logic [7:0] RST_SFR = 8'h00;
  // oscillator divider for the clock output pin
  localparam int OSC_OUT_HALF_NS = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_OUT_HALF_CYC = (OSC_OUT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {PWR_RUN, PWR_REG_SLEEP, PWR_PIN_DRAIN, PWR_PIN_SLEEP} uam_pwr_e;
endpackage : uam_pkg

// File: uam_ir_enc.sv
// infrared encoder: turns serial tx bits into short high pulses
// assumes a 16x bit tick and a bit-start strobe from the tx shifter
`timescale 1ns/1ps
module uam_ir_enc (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bit stream
  input wire logic tick16_i,
  input wire logic bit_start_i,
  input wire logic bit_i,
  input wire logic enh_i,
  // pulse out
  output logic pulse_o
);
  logic [3:0] phase;
  logic zero_bit;
  logic [3:0] width;

  // width per variant, sixteenths of a bit
  assign width = enh_i ? uam_pkg::IR_SIXTEENTHS_ENH : uam_pkg::IR_SIXTEENTHS_BASIC;

  // phase within the bit, restarted on every bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= 4'h0;
      zero_bit <= 1'b0;
    end else if (bit_start_i) begin
      phase <= 4'h0;
      zero_bit <= ~bit_i;
    end else if (tick16_i && phase != 4'hf) begin
      phase <= phase + 4'h1;
    end
  end

  // pulse only for zero bits, ones leave the led dark
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= zero_bit && (phase < width) && !bit_start_i;
    end
  end
endmodule : uam_ir_enc

// File: uam_ir_dec.sv
// infrared decoder: stretches each light pulse into a full zero bit
// assumes pulses on the receive pin are at least one clock wide
`timescale 1ns/1ps
module uam_ir_dec (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // line side
  input wire logic tick16_i,
  input wire logic pulse_i,
  // recovered uart level, idles high
  output logic rx_o
);
  logic [4:0] hold;

  // a pulse starts a bit-long low; idle pin low reads as mark
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold <= 5'h0;
    end else if (pulse_i) begin
      hold <= 5'h10;
    end else if (tick16_i && hold != 5'h0) begin
      hold <= hold - 5'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_o <= 1'b1;
    end else begin
      rx_o <= !(pulse_i || hold != 5'h0);
    end
  end
endmodule : uam_ir_dec

// File: uam_aux_modes.sv
// top of the uart auxiliary modes: multidrop tx marking, infrared, sleep, loopback
// assumes the core uart supplies shifter status, fifo levels and the 16x tick;
// control register fields arrive as plain ports, strobes are one clock wide
`timescale 1ns/1ps
module uam_aux_modes (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // control register fields
  input wire logic [7:0] SFR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] EFR_I,
  input wire logic [7:0] MCR_I,
  input wire logic [7:0] IER_I,
  input wire logic [7:0] FCR_I,
  input wire logic FCR_WR_I,
  input wire logic [7:0] LCR_I,
  // core status
  input wire logic INT_PENDING_I,
  input wire logic [3:0] MODEM_DELTA_I,
  input wire logic DIVISOR_NZ_I,
  input wire logic TX_FIFO_EMPTY_I,
  input wire logic RX_FIFO_EMPTY_I,
  input wire logic TSR_BUSY_I,
  input wire logic RSR_BUSY_I,
  input wire logic THR_WR_I,
  input wire logic ISR_RD_I,
  // core serial path
  input wire logic TICK16_I,
  input wire logic TX_BIT_START_I,
  input wire logic TX_SER_I,
  input wire logic PAR_BIT_I,
  input wire logic RTS_CORE_I,
  input wire logic DTR_CORE_I,
  // pins
  input wire logic RX_PIN_I,
  input wire logic SLEEP_PIN_I,
  input wire logic [3:0] MODEM_PIN_N_I,
  // to core
  output logic ADDR_MARK_O,
  output logic TX_NINTH_O,
  output logic RX_SER_O,
  output logic [3:0] MODEM_N_O,
  output logic FORCE0_OK_O,
  output logic CORE_RUN_O,
  output logic WAKE_INT_O,
  // pins out
  output logic TX_PIN_O,
  output logic RTS_N_O,
  output logic DTR_N_O,
  output logic OSC_OUT_O,
  output logic ASLEEP_O
);
  logic addr_mark;
  logic [7:0] sfr_q;
  logic ir_en;
  logic ir_enh;
  logic loop_en;
  logic ir_pulse;
  logic ir_rx;
  logic rx_line;
  logic rx_prev;
  logic [3:0] modem_prev;
  logic wake_ev;
  logic sleep_ok;
  logic wake_int_en;
  logic [1:0] osc_cnt;
  uam_pkg::uam_pwr_e pwr;
  uam_pkg::uam_pwr_e next_pwr;

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  assign ir_en = MCR_I[uam_pkg::MCR_IR_EN_BIT];
  assign ir_enh = ir_en && SFR_I[uam_pkg::SFR_IR_ENH_BIT]
                  && EFR_I[uam_pkg::EFR_ENH_EN_BIT];
  assign loop_en = MCR_I[uam_pkg::MCR_LOOP_BIT];

  ////////////////////////////////////////////////////////////////////////
  // address-marker flag: set by software, consumed by next transmit write
  // a new set in the same cycle as a write wins, so the next byte is marked
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      addr_mark <= 1'b0;
    end else if (SFR_WR_I) begin
      addr_mark <= SFR_I[uam_pkg::SFR_ADDR_MARK_BIT];
    end else if (THR_WR_I) begin
      addr_mark <= 1'b0;
    end
  end

  // ninth bit of the byte being written, travels with it into the fifo
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      TX_NINTH_O <= 1'b0;
    end else if (THR_WR_I) begin
      TX_NINTH_O <= addr_mark | PAR_BIT_I;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ADDR_MARK_O <= 1'b0;
      sfr_q <= uam_pkg::RST_SFR;
      FORCE0_OK_O <= 1'b0;
    end else begin
      ADDR_MARK_O <= addr_mark;
      sfr_q <= SFR_I;
      // status only: data bytes get a zero ninth bit if parity is forced zero
      FORCE0_OK_O <= LCR_I[uam_pkg::LCR_PARITY_LSB +: 3] == uam_pkg::LCR_PARITY_FORCE0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // infrared path
  uam_ir_enc u_enc (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .tick16_i(TICK16_I),
    .bit_start_i(TX_BIT_START_I),
    .bit_i(TX_SER_I),
    .enh_i(ir_enh),
    .pulse_o(ir_pulse)
  );

  uam_ir_dec u_dec (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .tick16_i(TICK16_I),
    .pulse_i(ir_en && RX_PIN_I),
    .rx_o(ir_rx)
  );

  // uart-level receive line before loopback
  assign rx_line = ir_en ? ir_rx : RX_PIN_I;

  ////////////////////////////////////////////////////////////////////////
  // loopback and pin drive
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      RX_SER_O <= 1'b1;
      TX_PIN_O <= 1'b1;
      RTS_N_O <= 1'b1;
      DTR_N_O <= 1'b1;
      MODEM_N_O <= 4'hf;
    end else begin
      RX_SER_O <= loop_en ? TX_SER_I : rx_line;
      // in loopback the pin is held high, mark on wire but lit in ir mode; ir mode pulses instead of levels
      TX_PIN_O <= loop_en ? 1'b1 : (ir_en ? ir_pulse : TX_SER_I);
      RTS_N_O <= loop_en ? 1'b1 : ~RTS_CORE_I;
      DTR_N_O <= loop_en ? 1'b1 : ~DTR_CORE_I;
      // modem inputs frozen at inactive while looping back
      MODEM_N_O <= loop_en ? 4'hf : MODEM_PIN_N_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake-event detection on the pins
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_prev <= 1'b1;
      modem_prev <= 4'hf;
    end else begin
      rx_prev <= rx_line;
      modem_prev <= MODEM_PIN_N_I;
    end
  end

  // start edge, transmit write or any modem change; loopback ignores modem pins
  assign wake_ev = (rx_prev && !rx_line) || THR_WR_I
                   || (!loop_en && (modem_prev != MODEM_PIN_N_I));

  // every condition for register-controlled sleep except no wake event, which the state machine adds
  assign sleep_ok = !INT_PENDING_I && IER_I[uam_pkg::IER_SLEEP_BIT]
                    && MODEM_DELTA_I == 4'h0 && rx_line && DIVISOR_NZ_I
                    && TX_FIFO_EMPTY_I && RX_FIFO_EMPTY_I
                    && !TSR_BUSY_I && !RSR_BUSY_I;

  ////////////////////////////////////////////////////////////////////////
  // power state machine
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      uam_pkg::PWR_RUN: begin
        if (SLEEP_PIN_I) begin
          next_pwr = uam_pkg::PWR_PIN_DRAIN;
        end else if (sleep_ok && !wake_ev) begin
          next_pwr = uam_pkg::PWR_REG_SLEEP;
        end
      end
      uam_pkg::PWR_REG_SLEEP: begin
        if (SLEEP_PIN_I) begin
          next_pwr = uam_pkg::PWR_PIN_DRAIN;
        end else if (wake_ev || !IER_I[uam_pkg::IER_SLEEP_BIT] || INT_PENDING_I) begin
          next_pwr = uam_pkg::PWR_RUN;
        end
      end
      uam_pkg::PWR_PIN_DRAIN: begin
        // fifos are left alone; only shifters must finish
        if (!SLEEP_PIN_I) begin
          next_pwr = uam_pkg::PWR_RUN;
        end else if (!TSR_BUSY_I && !RSR_BUSY_I) begin
          next_pwr = uam_pkg::PWR_PIN_SLEEP;
        end
      end
      uam_pkg::PWR_PIN_SLEEP: begin
        // register wake events have no effect here
        if (!SLEEP_PIN_I) begin
          next_pwr = uam_pkg::PWR_RUN;
        end
      end
      default: next_pwr = uam_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pwr <= uam_pkg::PWR_RUN;
    end else begin
      pwr <= next_pwr;
    end
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      ASLEEP_O <= 1'b0;
      CORE_RUN_O <= 1'b1;
    end else begin
      ASLEEP_O <= next_pwr == uam_pkg::PWR_REG_SLEEP || next_pwr == uam_pkg::PWR_PIN_SLEEP;
      // core clock gate: fifos hold their contents while stopped
      CORE_RUN_O <= !(next_pwr == uam_pkg::PWR_REG_SLEEP
                      || next_pwr == uam_pkg::PWR_PIN_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator output: toggles while awake, held low in sleep
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      osc_cnt <= 2'h0;
      OSC_OUT_O <= 1'b0;
    end else if (ASLEEP_O) begin
      osc_cnt <= 2'h0;
      OSC_OUT_O <= 1'b0;
    end else if (osc_cnt == 2'(uam_pkg::OSC_OUT_HALF_CYC - 1)) begin
      osc_cnt <= 2'h0;
      OSC_OUT_O <= ~OSC_OUT_O;
    end else begin
      osc_cnt <= osc_cnt + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake-up interrupt enable, written with the fifo control register
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      wake_int_en <= 1'b0;
    end else if (FCR_WR_I) begin
      wake_int_en <= FCR_I[uam_pkg::FCR_WAKE_INT_BIT];
    end
  end

  // sticky wake flag; a new wake in the clearing cycle wins
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      WAKE_INT_O <= 1'b0;
    end else if (wake_int_en && ASLEEP_O
                 && next_pwr == uam_pkg::PWR_RUN) begin
      WAKE_INT_O <= 1'b1;
    end else if (ISR_RD_I || !wake_int_en) begin
      WAKE_INT_O <= 1'b0;
    end
  end
endmodule : uam_aux_modes

// File: uam_aux_modes_sva.sv
// checker for uam_aux_modes: marking, loopback and sleep relations
// assumes binding to the top ports; registered outputs lag inputs by one clock
`timescale 1ns/1ps
module uam_aux_modes_sva (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // inputs watched
  input wire logic [7:0] SFR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] MCR_I,
  input wire logic [7:0] IER_I,
  input wire logic THR_WR_I,
  input wire logic PAR_BIT_I,
  input wire logic INT_PENDING_I,
  input wire logic TSR_BUSY_I,
  input wire logic SLEEP_PIN_I,
  input wire logic TX_SER_I,
  // outputs watched
  input wire logic TX_NINTH_O,
  input wire logic RX_SER_O,
  input wire logic [3:0] MODEM_N_O,
  input wire logic TX_PIN_O,
  input wire logic OSC_OUT_O,
  input wire logic ASLEEP_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);
  ////////////////////////////////////////
  // marker written, one quiet clock, then the byte it marks
  sequence s_mark;
    SFR_WR_I && SFR_I[7] ##1 !SFR_WR_I && !THR_WR_I ##1 THR_WR_I && !SFR_WR_I;
  endsequence
  // a byte write spends any marker, so the next one is plain
  sequence s_plain;
    THR_WR_I && !SFR_WR_I ##1 !SFR_WR_I ##1 THR_WR_I && !SFR_WR_I;
  endsequence
  a_mark_ninth: assert property (s_mark |=> TX_NINTH_O)
    else $error("marked byte lost its ninth bit");
  a_mark_spent: assert property (s_plain |=> TX_NINTH_O == $past(PAR_BIT_I))
    else $error("marker did not clear itself");
  a_loop_pins: assert property (MCR_I[4] |=> TX_PIN_O && MODEM_N_O == 4'hf)
    else $error("loopback pins not parked");
  a_loop_data: assert property (MCR_I[4] |=> RX_SER_O == $past(TX_SER_I))
    else $error("loopback data not routed");
  a_int_no_sleep: assert property (INT_PENDING_I && !SLEEP_PIN_I |=> !ASLEEP_O)
    else $error("asleep with interrupt pending");
  a_busy_no_sleep: assert property (TSR_BUSY_I && !ASLEEP_O |=> !ASLEEP_O)
    else $error("slept with shifter busy");
  a_sleep_off: assert property (!IER_I[4] && !SLEEP_PIN_I |=> !ASLEEP_O)
    else $error("asleep with sleep disabled");
  a_osc_stopped: assert property (ASLEEP_O [*2] |-> !OSC_OUT_O)
    else $error("oscillator runs in sleep");
endmodule : uam_aux_modes_sva

// File: uam_line_model.sv
// far station on the receive pin: wire uart or infrared transceiver
// assumes one start bit per request, 16 ticks long
`timescale 1ns/1ps
module uam_line_model (
  // clock and mode
  input wire logic clk_i,
  input wire logic ir_i,
  input wire logic tick16_i,
  // one-clock request to send a zero bit
  input wire logic send_i,
  // receive pin of the device
  output logic rx_pin_o
);
  logic [4:0] cnt = 5'h00;
  // bit timer in ticks
  always_ff @(posedge clk_i) begin
    if (send_i) begin
      cnt <= 5'h10;
    end else if (tick16_i && cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end
  // idle is mark: high on wire, dark in infrared; a zero lights 3 ticks
  assign rx_pin_o = ir_i ? (cnt > 5'h0d) : (cnt == 5'h00);
endmodule : uam_line_model

// File: uam_aux_modes_bench.sv
// testbench for uam_aux_modes: multidrop, infrared, loopback, sleep
// assumes the line model on the receive pin; inputs change on falling edges
`timescale 1ns/1ps
module uam_aux_modes_bench;
  logic mclk, rst, sfr_wr, fcr_wr, irq, tsr_busy, thr_wr, isr_rd, bstart, tx_ser;
  logic rts_core, sleep_pin, send, rx_pin, ninth, rx_ser, f0_ok, wake_int, tx_pin;
  logic rts_n, osc, asleep, tx_empty;
  logic amark, core_run, dtr_n, osc_last;
  logic tick = 1'b0;
  logic [7:0] special_function_reg, enhanced_function_reg, modem_control_reg, interrupt_enable_reg, fifo_control_reg, line_control_reg;
  logic [3:0] delta, modem, modem_n;
  int fails = 0;
  int n_compared = 0;
  uam_aux_modes uut (
    .MCLK_I(mclk), .RST_I(rst), .SFR_I(special_function_reg), .SFR_WR_I(sfr_wr), .EFR_I(enhanced_function_reg), .MCR_I(modem_control_reg),
    .IER_I(interrupt_enable_reg), .FCR_I(fifo_control_reg), .FCR_WR_I(fcr_wr), .LCR_I(line_control_reg), .INT_PENDING_I(irq),
    .MODEM_DELTA_I(delta), .DIVISOR_NZ_I(1'b1), .TX_FIFO_EMPTY_I(tx_empty),
    .RX_FIFO_EMPTY_I(1'b1), .TSR_BUSY_I(tsr_busy), .RSR_BUSY_I(1'b0), .THR_WR_I(thr_wr),
    .ISR_RD_I(isr_rd), .TICK16_I(tick), .TX_BIT_START_I(bstart), .TX_SER_I(tx_ser),
    .PAR_BIT_I(1'b0), .RTS_CORE_I(rts_core), .DTR_CORE_I(1'b1), .RX_PIN_I(rx_pin),
    .SLEEP_PIN_I(sleep_pin), .MODEM_PIN_N_I(modem), .ADDR_MARK_O(amark), .TX_NINTH_O(ninth),
    .RX_SER_O(rx_ser), .MODEM_N_O(modem_n), .FORCE0_OK_O(f0_ok), .CORE_RUN_O(core_run),
    .WAKE_INT_O(wake_int), .TX_PIN_O(tx_pin), .RTS_N_O(rts_n), .DTR_N_O(dtr_n),
    .OSC_OUT_O(osc), .ASLEEP_O(asleep));
  uam_line_model far (.clk_i(mclk), .ir_i(modem_control_reg[6]), .tick16_i(tick), .send_i(send),
    .rx_pin_o(rx_pin));
  ////////////////////////////////////////
  // clock, and a tick every other cycle so widths show as clock pairs
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(negedge mclk) tick <= ~tick;
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // width in ticks, rounded since the tick phase against the bit start is free
  task automatic ir_width(input logic b, input logic [7:0] exp);
    int n;
    n = 0;
    tx_ser = b;
    pulse(bstart);
    repeat (40) begin
      n += int'(tx_pin === 1'b1);
      @(negedge mclk);
    end
    check("ir pulse", 8'((n + 1) / 2), exp);
  endtask : ir_width
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    results();
  end
  initial begin
    {sfr_wr, fcr_wr, irq, tsr_busy, thr_wr, isr_rd, bstart, rts_core, sleep_pin, send} = '0;
    {special_function_reg, enhanced_function_reg, modem_control_reg, interrupt_enable_reg, fifo_control_reg, line_control_reg} = '0;
    {delta, modem, tx_ser, tx_empty, rst} = 11'h07f;
    cyc(5);
    rst = 1'b0;
    cyc(2);
    check("wake int rst", wake_int, 1'b0);
    // multidrop: a marked byte, then a plain one
    line_control_reg = 8'h38;
    special_function_reg = 8'h80;
    pulse(sfr_wr);
    cyc(1);
    check("mark flag", amark, 1'b1);
    pulse(thr_wr);
    cyc(1);
    check("ninth marked", ninth, 1'b1);
    check("mark spent", amark, 1'b0);
    special_function_reg = 8'h00;
    pulse(thr_wr);
    cyc(1);
    check("ninth plain", ninth, 1'b0);
    check("force zero", f0_ok, 1'b1);
    $display("multidrop test done");
    // infrared: one bit dark, basic, enhanced bit alone, enhanced
    modem_control_reg = 8'h40;
    cyc(2);
    check("ir rx idle", rx_ser, 1'b1);
    ir_width(1'b1, 8'h00);
    ir_width(1'b0, 8'h03);
    special_function_reg = 8'h08;
    ir_width(1'b0, 8'h03);
    enhanced_function_reg = 8'h10;
    ir_width(1'b0, 8'h04);
    pulse(send);
    cyc(3);
    check("ir rx pulse", rx_ser, 1'b0);
    cyc(50);
    check("ir rx end", rx_ser, 1'b1);
    {special_function_reg, enhanced_function_reg} = '0;
    $display("infrared test done");
    // loopback with core requests and modem pins active
    modem_control_reg = 8'h10;
    rts_core = 1'b1;
    modem = 4'h0;
    tx_ser = 1'b0;
    cyc(2);
    check("loop tx pin", tx_pin, 1'b1);
    check("loop rts", rts_n, 1'b1);
    check("loop dtr", dtr_n, 1'b1);
    check("loop modem", modem_n, 4'hf);
    check("loop data", rx_ser, 1'b0);
    modem_control_reg = 8'h00;
    cyc(2);
    check("rts normal", rts_n, 1'b0);
    check("dtr normal", dtr_n, 1'b0);
    osc_last = osc;
    cyc(1);
    check("osc run", osc, !osc_last);
    tx_ser = 1'b1;
    modem = 4'hf;
    $display("loopback test done");
    // register sleep, each wake source, automatic re-entry
    fifo_control_reg = 8'h08;
    pulse(fcr_wr);
    interrupt_enable_reg = 8'h10;
    cyc(4);
    check("reg sleep", asleep, 1'b1);
    check("osc stop", osc, 1'b0);
    check("core stop", core_run, 1'b0);
    pulse(thr_wr);
    check("thr wake", asleep, 1'b0);
    irq = 1'b1;
    cyc(4);
    check("pending", asleep, 1'b0);
    check("wake int", wake_int, 1'b1);
    irq = 1'b0;
    pulse(isr_rd);
    cyc(3);
    check("int cleared", wake_int, 1'b0);
    check("resleep", asleep, 1'b1);
    modem = 4'he;
    delta = 4'h1;
    cyc(2);
    check("modem wake", asleep, 1'b0);
    delta = 4'h0;
    pulse(isr_rd);
    cyc(3);
    check("resleep modem", asleep, 1'b1);
    pulse(send);
    cyc(2);
    check("rx wake", asleep, 1'b0);
    cyc(40);
    pulse(isr_rd);
    cyc(3);
    check("resleep rx", asleep, 1'b1);
    interrupt_enable_reg = 8'h00;
    cyc(10);
    check("sleep off", asleep, 1'b0);
    $display("register sleep test done");
    // pin sleep with data still in the fifo
    tx_empty = 1'b0;
    tsr_busy = 1'b1;
    sleep_pin = 1'b1;
    cyc(5);
    check("drain", asleep, 1'b0);
    tsr_busy = 1'b0;
    cyc(3);
    check("pin sleep", asleep, 1'b1);
    check("pin core stop", core_run, 1'b0);
    pulse(thr_wr);
    cyc(2);
    check("pin hold", asleep, 1'b1);
    sleep_pin = 1'b0;
    cyc(3);
    check("pin wake", asleep, 1'b0);
    $display("pin sleep test done");
    results();
  end
endmodule : uam_aux_modes_bench
bind uam_aux_modes uam_aux_modes_sva u_sva (.MCLK_I(MCLK_I), .RST_I(RST_I), .SFR_I(SFR_I),
  .SFR_WR_I(SFR_WR_I), .MCR_I(MCR_I), .IER_I(IER_I), .THR_WR_I(THR_WR_I),
  .PAR_BIT_I(PAR_BIT_I), .INT_PENDING_I(INT_PENDING_I), .TSR_BUSY_I(TSR_BUSY_I),
  .SLEEP_PIN_I(SLEEP_PIN_I), .TX_SER_I(TX_SER_I), .TX_NINTH_O(TX_NINTH_O),
  .RX_SER_O(RX_SER_O), .MODEM_N_O(MODEM_N_O), .TX_PIN_O(TX_PIN_O), .OSC_OUT_O(OSC_OUT_O),
  .ASLEEP_O(ASLEEP_O));
